// file: hdl/sac_consts.svh
// Constants for the converter control block: offsets, fields, reset values
// and conversion step counts. Definitions only.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// Word-aligned byte offsets on the register bus
`define SAC_OFS_CTRL 4'h0
`define SAC_OFS_RESH 4'h4
`define SAC_OFS_RESL 4'h8
`define SAC_OFS_CLK 4'hC

// Status/control register fields
`define SAC_CTRL_DONE 7
`define SAC_CTRL_IRQEN 6
`define SAC_CTRL_CONT 5
`define SAC_CTRL_CH_HI 4

// Clock register fields
`define SAC_CLK_DIV_HI 7
`define SAC_CLK_DIV_LO 5
`define SAC_CLK_SRC 4
`define SAC_CLK_MODE_HI 3
`define SAC_CLK_MODE_LO 2

// Reset values
`define SAC_RST_CH 5'h1F
`define SAC_RST_DIV 3'h0
`define SAC_RST_SRC 1'b0
`define SAC_RST_MODE 2'h1

// Special channel codes
`define SAC_CH_OFF 5'h1F
`define SAC_CH_PINS 5'h08

// Conversion length in converter clocks, and sampling part of it
`define SAC_CONV_TICKS 5'h10
`define SAC_SAMPLE_TICKS 5'h06

`endif

// file: hdl/sac_pkg.sv
// Types for the converter control block.
// Assumes sac_consts.svh is used alongside for all numeric constants.
package sac_pkg;

   // Result layout selection
   typedef enum logic [1:0] {
      SAC_FMT_TRUNC8 = 2'h0,
      SAC_FMT_RIGHT = 2'h1,
      SAC_FMT_LEFT = 2'h2,
      SAC_FMT_LEFT_SIGNED = 2'h3
   } sac_fmt_t;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      SAC_ST_IDLE = 3'h1,
      SAC_ST_ALIGN = 3'h2,
      SAC_ST_CONV = 3'h4
   } sac_state_t;

   // Status/control register contents
   typedef struct packed {
      logic done;
      logic irq_en;
      logic cont;
      logic [4:0] chan;
   } sac_ctrl_t;

   // Clock register contents
   typedef struct packed {
      logic [2:0] div;
      logic src_bus;
      sac_fmt_t fmt;
   } sac_clk_t;

   // Formatted result pair
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } sac_result_t;

endpackage : sac_pkg

// file: hdl/sac_top.sv
// Converter control block: Wishbone register slave, prescaler, SAR
// sequencer, result formatting with high/low interlock, pin takeover.
// Assumes an external comparator that reports input >= trial code, and a
// port block that supplies its data and direction registers.
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_top #(
   parameter int PINS = 8,
   parameter int RES_W = 10
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Converter clock source
   input wire logic ext_reference_clock,
   // Analog side: mux select, trial code, comparator
   output logic [4:0] selected_analog_input,
   output logic conv_power_on,
   output logic [RES_W-1:0] trial_code,
   output logic sample_hold,
   input wire logic cmp_ge,
   // Shared port pins and port logic
   input wire logic [PINS-1:0] port_data,
   input wire logic [PINS-1:0] port_dir,
   input wire logic [PINS-1:0] shared_port_pins_i,
   output logic [PINS-1:0] shared_port_pins_o,
   output logic [PINS-1:0] shared_port_pins_oe,
   output logic [PINS-1:0] port_read_data,
   // Interrupt request to the CPU
   output logic conv_irq
);

   // Registers
   sac_pkg::sac_ctrl_t ctrl_r, ctrl_nxt;
   sac_pkg::sac_clk_t clk_reg_r, clk_reg_nxt;
   sac_pkg::sac_result_t res_r, res_nxt;
   logic hold_r, hold_nxt;
   logic irq_r, irq_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic ref_d_r;
   logic [3:0] pre_r, pre_nxt;
   sac_pkg::sac_state_t st_r, st_nxt;
   logic [4:0] tick_cnt_r, tick_cnt_nxt;
   logic [RES_W-1:0] trial_r, trial_nxt;
   logic [RES_W-1:0] conv_val_r, conv_val_nxt;
   logic done_r, done_nxt;
   logic [PINS-1:0] pin_o_r, pin_oe_r, prd_r;
   logic [PINS-1:0] pin_o_nxt, pin_oe_nxt, prd_nxt;
   // Registered copies of power and sample/hold for the output pins
   logic pwr_r, pwr_nxt;
   logic smp_r, smp_nxt;

   // Bus decode
   logic bus_req, wr_acc, rd_acc;
   logic wr_ctrl, wr_clk, rd_high, rd_low;
   logic adc_on;
   logic src_tick, adc_tick;
   logic [3:0] pre_max;
   logic [PINS-1:0] pin_taken;
   logic [3:0] bit_idx;

   // New request only when no ack is pending; ack drops the cycle after
   // Writes with sel[0] low are still acked but change nothing
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_acc = bus_req & wb_we_i & wb_sel_i[0];
   assign rd_acc = bus_req & ~wb_we_i;
   assign wr_ctrl = wr_acc && wb_adr_i == `SAC_OFS_CTRL;
   assign wr_clk = wr_acc && wb_adr_i == `SAC_OFS_CLK;
   assign rd_high = rd_acc && wb_adr_i == `SAC_OFS_RESH;
   assign rd_low = rd_acc && wb_adr_i == `SAC_OFS_RESL;
   assign adc_on = ctrl_r.chan != `SAC_CH_OFF;

   // Converter clock source: bus clock each cycle or reference rising edge
   // Limitation: the reference is sampled as a level, so it must stay well
   // below half the bus clock rate or edges are lost
   assign src_tick = clk_reg_r.src_bus | (ext_reference_clock & ~ref_d_r);

   // Prescale: 1, 2, 4, 8, or 16 for any code with the top bit set
   always_comb begin
      unique case (clk_reg_r.div[1:0])
         2'h0: pre_max = 4'h0;
         2'h1: pre_max = 4'h1;
         2'h2: pre_max = 4'h3;
         default: pre_max = 4'h7;
      endcase
      if (clk_reg_r.div[2])
         pre_max = 4'hF;
   end
   assign adc_tick = src_tick && pre_r == pre_max;

   // Prescaler counts source ticks; a start write realigns it, so the
   // partial first converter cycle is never longer than one period
   always_comb begin
      pre_nxt = pre_r;
      if (wr_ctrl || !adc_on)
         pre_nxt = 4'h0;
      else if (adc_tick)
         pre_nxt = 4'h0;
      else if (src_tick)
         pre_nxt = pre_r + 4'h1;
   end

   // Bit under test during the resolve ticks
   assign bit_idx = 4'(`SAC_CONV_TICKS - 5'h1 - tick_cnt_r);

   // Sequencer: align to first converter clock, sample, then resolve bits
   always_comb begin
      st_nxt = st_r;
      tick_cnt_nxt = tick_cnt_r;
      trial_nxt = trial_r;
      conv_val_nxt = conv_val_r;
      done_nxt = 1'b0;
      unique case (st_r)
         sac_pkg::SAC_ST_IDLE: begin
         end
         sac_pkg::SAC_ST_ALIGN: begin
            // Partial cycle before the first converter edge
            if (adc_tick) begin
               st_nxt = sac_pkg::SAC_ST_CONV;
               tick_cnt_nxt = 5'h0;
            end
         end
         sac_pkg::SAC_ST_CONV: begin
            if (adc_tick) begin
               tick_cnt_nxt = tick_cnt_r + 5'h1;
               if (tick_cnt_r == `SAC_SAMPLE_TICKS - 5'h1)
                  trial_nxt = RES_W'(1) << (RES_W - 1);
               if (tick_cnt_r >= `SAC_SAMPLE_TICKS) begin
                  // Keep the trial bit only if input reaches it
                  conv_val_nxt = trial_r;
                  if (!cmp_ge)
                     conv_val_nxt[bit_idx] = 1'b0;
                  trial_nxt = conv_val_nxt;
                  if (bit_idx != 4'h0)
                     trial_nxt[bit_idx - 4'h1] = 1'b1;
               end
               if (tick_cnt_r == `SAC_CONV_TICKS - 5'h1) begin
                  done_nxt = 1'b1;
                  tick_cnt_nxt = 5'h0;
                  // Clear the trial so the comparator sees a known code
                  trial_nxt = '0;
                  if (!ctrl_r.cont)
                     st_nxt = sac_pkg::SAC_ST_IDLE;
               end
            end
         end
         default: st_nxt = sac_pkg::SAC_ST_IDLE;
      endcase
      // Start write abandons anything running and restarts
      if (wr_ctrl) begin
         st_nxt = sac_pkg::SAC_ST_ALIGN;
         tick_cnt_nxt = 5'h0;
         trial_nxt = '0;
         done_nxt = 1'b0;
      end
      if (!adc_on && !wr_ctrl)
         st_nxt = sac_pkg::SAC_ST_IDLE;
      // Power-off code in the start write wins: nothing starts
      if (wr_ctrl && wb_dat_i[`SAC_CTRL_CH_HI:0] == `SAC_CH_OFF)
         st_nxt = sac_pkg::SAC_ST_IDLE;
   end

   // Result formatting and storage
   always_comb begin
      res_nxt = res_r;
      hold_nxt = hold_r;
      if (rd_low)
         hold_nxt = 1'b0;
      else if (rd_high && clk_reg_r.fmt != sac_pkg::SAC_FMT_TRUNC8)
         hold_nxt = 1'b1;
      // Stores every completion, also in continuous mode, unless held.
      // Truncation has no pair to protect, so a hold left open from an
      // earlier mode must not block it
      if (done_r && (!hold_r ||
            clk_reg_r.fmt == sac_pkg::SAC_FMT_TRUNC8)) begin
         unique case (clk_reg_r.fmt)
            sac_pkg::SAC_FMT_TRUNC8: begin
               res_nxt.high = 8'h00;
               res_nxt.low = conv_val_r[RES_W-1 -: 8];
            end
            sac_pkg::SAC_FMT_RIGHT: begin
               res_nxt.high = {6'h00, conv_val_r[RES_W-1 -: 2]};
               res_nxt.low = conv_val_r[7:0];
            end
            sac_pkg::SAC_FMT_LEFT: begin
               res_nxt.high = conv_val_r[RES_W-1 -: 8];
               res_nxt.low = {conv_val_r[1:0], 6'h00};
            end
            sac_pkg::SAC_FMT_LEFT_SIGNED: begin
               res_nxt.high = {~conv_val_r[RES_W-1],
                  conv_val_r[RES_W-2 -: 7]};
               res_nxt.low = {conv_val_r[1:0], 6'h00};
            end
         endcase
      end
   end

   // Control and clock registers, done flag and interrupt request
   always_comb begin
      ctrl_nxt = ctrl_r;
      clk_reg_nxt = clk_reg_r;
      irq_nxt = irq_r;
      if (wr_ctrl) begin
         ctrl_nxt.irq_en = wb_dat_i[`SAC_CTRL_IRQEN];
         ctrl_nxt.cont = wb_dat_i[`SAC_CTRL_CONT];
         ctrl_nxt.chan = wb_dat_i[`SAC_CTRL_CH_HI:0];
         // Flag is read only unless interrupts are enabled
         ctrl_nxt.done = wb_dat_i[`SAC_CTRL_IRQEN] &
            wb_dat_i[`SAC_CTRL_DONE];
         irq_nxt = 1'b0;
      end
      if (wr_clk) begin
         clk_reg_nxt.div = wb_dat_i[`SAC_CLK_DIV_HI:`SAC_CLK_DIV_LO];
         clk_reg_nxt.src_bus = wb_dat_i[`SAC_CLK_SRC];
         clk_reg_nxt.fmt = sac_pkg::sac_fmt_t'(
            wb_dat_i[`SAC_CLK_MODE_HI:`SAC_CLK_MODE_LO]);
      end
      if (rd_high || rd_low) begin
         if (!ctrl_r.irq_en)
            ctrl_nxt.done = 1'b0;
         irq_nxt = 1'b0;
      end
      // Completion wins over a clear in the same cycle. With interrupts
      // on, software owns the done bit and a set bit masks the request.
      if (done_r && !wr_ctrl) begin
         if (ctrl_r.irq_en && !ctrl_r.done)
            irq_nxt = 1'b1;
         else if (!ctrl_r.irq_en)
            ctrl_nxt.done = 1'b1;
      end
      if (done_r && wr_ctrl && !wb_dat_i[`SAC_CTRL_IRQEN])
         ctrl_nxt.done = 1'b1;
      if (done_r && wr_ctrl && wb_dat_i[`SAC_CTRL_IRQEN] &&
            !wb_dat_i[`SAC_CTRL_DONE])
         irq_nxt = 1'b1;
   end

   // Bus answer: one cycle ack with registered read data
   // Ack is registered, so with ce high every transfer spans two edges, never more
   always_comb begin
      ack_nxt = bus_req;
      dat_nxt = 32'h0000_0000;
      if (rd_acc) begin
         unique case (wb_adr_i)
            `SAC_OFS_CTRL: dat_nxt[7:0] = ctrl_r;
            `SAC_OFS_RESH: dat_nxt[7:0] = res_r.high;
            `SAC_OFS_RESL: dat_nxt[7:0] = res_r.low;
            `SAC_OFS_CLK: dat_nxt[7:0] = {clk_reg_r, 2'h0};
            default: dat_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Pin takeover: only a pin channel with the converter powered
   // Takeover is registered: a channel change frees or grabs its pin one
   // cycle after the control write lands
   always_comb begin
      pin_taken = '0;
      if (adc_on && ctrl_r.chan < `SAC_CH_PINS)
         pin_taken[ctrl_r.chan[2:0]] = 1'b1;
      pin_o_nxt = port_data & ~pin_taken;
      pin_oe_nxt = port_dir & ~pin_taken;
      prd_nxt = shared_port_pins_i & ~pin_taken;
   end

   // Power and sample/hold outputs come from flops; they are computed
   // from the next state so they change on the same edge as the state
   always_comb begin
      pwr_nxt = ctrl_nxt.chan != `SAC_CH_OFF;
      smp_nxt = st_nxt != sac_pkg::SAC_ST_CONV ||
         tick_cnt_nxt < `SAC_SAMPLE_TICKS;
   end

   // Register stage; clock enable freezes everything
   // Synchronous reset only; ce low holds the bus ack as well
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= '{done: 1'b0, irq_en: 1'b0, cont: 1'b0,
            chan: `SAC_RST_CH};
         clk_reg_r <= '{div: `SAC_RST_DIV, src_bus: `SAC_RST_SRC,
            fmt: sac_pkg::sac_fmt_t'(`SAC_RST_MODE)};
         res_r <= '0;
         hold_r <= 1'b0;
         irq_r <= 1'b0;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         ref_d_r <= 1'b0;
         pre_r <= 4'h0;
         st_r <= sac_pkg::SAC_ST_IDLE;
         tick_cnt_r <= 5'h0;
         trial_r <= '0;
         conv_val_r <= '0;
         done_r <= 1'b0;
         pin_o_r <= '0;
         pin_oe_r <= '0;
         prd_r <= '0;
         pwr_r <= 1'b0;
         smp_r <= 1'b1;
      end else if (ce) begin
         ctrl_r <= ctrl_nxt;
         clk_reg_r <= clk_reg_nxt;
         res_r <= res_nxt;
         hold_r <= hold_nxt;
         irq_r <= irq_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         ref_d_r <= ext_reference_clock;
         pre_r <= pre_nxt;
         st_r <= st_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         trial_r <= trial_nxt;
         conv_val_r <= conv_val_nxt;
         done_r <= done_nxt;
         pin_o_r <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
         prd_r <= prd_nxt;
         pwr_r <= pwr_nxt;
         smp_r <= smp_nxt;
      end
   end

   // Outputs, all from flops
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign selected_analog_input = ctrl_r.chan;
   assign conv_power_on = pwr_r;
   assign trial_code = trial_r;
   assign sample_hold = smp_r;
   assign shared_port_pins_o = pin_o_r;
   assign shared_port_pins_oe = pin_oe_r;
   assign port_read_data = prd_r;
   assign conv_irq = irq_r;

endmodule : sac_top

// file: bench/sac_assertions.sv
// Checker for the converter control block, bound to its top ports.
// Assumes ce is held high for the whole run.
`timescale 1ns/1ps
module sac_assertions #(
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Converter and pins
   input wire logic [4:0] selected_analog_input,
   input wire logic conv_power_on,
   input wire logic sample_hold,
   input wire logic conv_irq,
   input wire logic [PINS-1:0] port_dir,
   input wire logic [PINS-1:0] shared_port_pins_i,
   input wire logic [PINS-1:0] shared_port_pins_oe,
   input wire logic [PINS-1:0] port_read_data,
   input wire logic [PINS-1:0] port_data,
   input wire logic [PINS-1:0] shared_port_pins_o
);
   // Pin held by the converter; codes 8 and up take none
   logic [PINS-1:0] mask;
   assign mask = (selected_analog_input < 5'h08) ?
      PINS'(1) << selected_analog_input[2:0] : '0;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr;
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 4'h0
         && wb_sel_i[0];
   endsequence
   sequence s_start;
      s_wr ##0 wb_dat_i[4:0] != 5'h1F;
   endsequence
   // Registered pin logic lags the channel by one cycle, so wait for it
   sequence s_settled;
      $stable(selected_analog_input) && !$past(rst);
   endsequence
   property p_chan;
      s_wr |=> selected_analog_input == $past(wb_dat_i[4:0]);
   endproperty
   a_chan: assert property (p_chan) else $error("channel");
   property p_take;
      s_settled |-> shared_port_pins_oe == ($past(port_dir) & ~mask);
   endproperty
   a_take: assert property (p_take) else $error("pin drive");
   property p_rd_zero;
      s_settled |-> port_read_data == ($past(shared_port_pins_i) & ~mask);
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("pin read");
   property p_drive;
      s_settled |-> shared_port_pins_o == ($past(port_data) & ~mask);
   endproperty
   a_drive: assert property (p_drive) else $error("pin data");
   property p_power;
      conv_power_on == (selected_analog_input != 5'h1F);
   endproperty
   a_power: assert property (p_power) else $error("power");
   property p_start;
      s_start |=> ##[1:1000] !sample_hold;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_abort;
      s_start ##0 !sample_hold |=> sample_hold;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_conv_len;
      $fell(sample_hold) |-> ##[1:1000] sample_hold;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("length");
   property p_irq_clr;
      s_wr |=> !conv_irq;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq kept");
endmodule : sac_assertions

// file: bench/sac_analog_model.sv
// Far side: analog levels behind the channel mux, comparator, pins.
// Assumes the bench supplies one level word, skewed per channel.
`timescale 1ns/1ps
module sac_analog_model (
   // Clock
   input wire logic clk,
   // Converter side
   input wire logic [4:0] selected_analog_input,
   input wire logic [9:0] trial_code,
   input wire logic [9:0] level,
   output logic cmp_ge,
   // Shared pins
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe,
   output logic [7:0] pin_i
);
   logic [9:0] vin;
   logic [7:0] drift = 8'h00;
   // References clip to full and zero scale
   always_comb begin
      case (selected_analog_input)
         5'h1D: vin = 10'h3FF;
         5'h1E: vin = 10'h000;
         default: vin = level ^ {selected_analog_input[2:0], 7'h00};
      endcase
   end
   assign cmp_ge = vin >= trial_code;
   // Undriven pins float, so show a pattern that moves every cycle
   always @(posedge clk) drift <= drift + 8'h01;
   assign pin_i = (pin_o & pin_oe) | (~drift & ~pin_oe);
endmodule : sac_analog_model

// file: bench/sac_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes the analog model answers the comparator with no delay.
`timescale 1ns/1ps
module sac_top_tb;
   logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, ext_reference_clock = 1'b0, cmp_ge, conv_irq;
   logic wb_ack_o, sample_hold, conv_power_on;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [4:0] selected_analog_input, ch;
   logic [9:0] trial_code, base = 10'h000;
   logic [7:0] port_data = 8'h00, port_dir = 8'h00, shared_port_pins_i, q;
   logic [7:0] shared_port_pins_o, shared_port_pins_oe, port_read_data;
   logic [15:0] r, e;
   int err_total = 0, tests_run = 0, cycles = 0, seed = 32'h5E5F6612;
   sac_top i_dut (.clk, .rst, .ce(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .ext_reference_clock, .selected_analog_input, .conv_power_on,
      .trial_code, .sample_hold, .cmp_ge, .port_data, .port_dir,
      .shared_port_pins_i, .shared_port_pins_o, .shared_port_pins_oe,
      .port_read_data, .conv_irq);
   sac_analog_model i_far (.clk, .selected_analog_input, .trial_code,
      .level(base), .cmp_ge, .pin_o(shared_port_pins_o),
      .pin_oe(shared_port_pins_oe), .pin_i(shared_port_pins_i));
   // Bus clock
   initial forever #4 clk = ~clk;
   // Port logic rewrites every pin each cycle; reference clock at a
   // sixth of the bus clock; hang guard
   always @(posedge clk) begin
      if (cycles % 3 == 0)
         ext_reference_clock <= ~ext_reference_clock;
      port_data <= 8'($random(seed));
      port_dir <= 8'($random(seed));
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   function automatic int lvl(input int c);
      if (c == 29) return 1023;
      if (c == 30) return 0;
      return int'(base ^ 10'(c << 7));
   endfunction : lvl
   // Expected high/low pair for each layout
   function automatic logic [15:0] fx(input int f, input int v);
      logic [9:0] w;
      w = 10'(v);
      case (f)
         0: return {8'h00, w[9:2]};
         1: return {6'h00, w};
         2: return {w[9:2], w[1:0], 6'h00};
         default: return {~w[9], w[8:2], w[1:0], 6'h00};
      endcase
   endfunction : fx
   task automatic chk(input string n, input logic [15:0] s,
         input logic [15:0] x);
      tests_run++;
      if (s !== x) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   // One classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [3:0] ad,
         input logic [7:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'hF;
      wb_adr_i <= ad;
      wb_dat_i <= {24'h000000, d};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_sel_i <= 4'h0;
   endtask : bus
   task automatic conv(input logic [7:0] c);
      bus(1'b1, 4'h0, c);
      q = 8'h00;
      for (int i = 0; i < 300 && q[7] !== 1'b1; i++) bus(1'b0, 4'h0, 8'h00);
   endtask : conv
   task automatic getres();
      bus(1'b0, 4'h4, 8'h00);
      r[15:8] = q;
      bus(1'b0, 4'h8, 8'h00);
      r[7:0] = q;
   endtask : getres
   task automatic tally_and_finish();
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 8'h00);
      chk("ctrl reset", 16'(q), 16'h001F);
      bus(1'b0, 4'hC, 8'h00);
      chk("clock reset", 16'(q), 16'h0004);
      bus(1'b1, 4'h1, 8'hFF);
      bus(1'b0, 4'h1, 8'h00);
      chk("unmapped", 16'(q), 16'h0000);
      // Every layout code, then both reference inputs
      for (int i = 0; i < 6; i++) begin
         ch = (i < 4) ? 5'($random(seed)) & 5'h07 : 5'h1D + 5'(i - 4);
         base <= 10'($random(seed));
         bus(1'b1, 4'hC, 8'h10 | 8'(i % 4) << 2);
         conv({3'h0, ch});
         getres();
         chk("layout", r, fx(i % 4, lvl(ch)));
      end
      // High read holds the pair; the next result is lost
      bus(1'b1, 4'hC, 8'h18);
      conv(8'h03);
      e = fx(2, lvl(3));
      bus(1'b0, 4'h4, 8'h00);
      base <= ~base;
      bus(1'b1, 4'h0, 8'h43);
      for (int i = 0; i < 300 && conv_irq !== 1'b1; i++) @(posedge clk);
      chk("irq", 16'(conv_irq), 16'h0001);
      bus(1'b0, 4'h8, 8'h00);
      chk("held low", 16'(q), {8'h00, e[7:0]});
      getres();
      chk("held pair", r, e);
      // Truncation has no pairing
      bus(1'b1, 4'hC, 8'h10);
      conv(8'h05);
      bus(1'b0, 4'h4, 8'h00);
      chk("trunc high", 16'(q), 16'h0000);
      base <= base + 10'h0AB;
      conv(8'h05);
      bus(1'b0, 4'h8, 8'h00);
      chk("trunc low", 16'(q), fx(0, lvl(5)));
      // Continuous mode keeps overwriting while the flag stays up
      bus(1'b1, 4'hC, 8'h14);
      conv(8'h22);
      base <= 10'($random(seed));
      repeat (60) @(posedge clk);
      bus(1'b0, 4'h0, 8'h00);
      chk("cont flag", 16'(q[7]), 16'h0001);
      getres();
      chk("cont data", r, fx(1, lvl(2)));
      bus(1'b1, 4'h0, 8'h1F);
      chk("power off", 16'(conv_power_on), 16'h0000);
      // Rewrite mid-conversion, then the divided reference clock
      bus(1'b1, 4'h0, 8'h01);
      repeat (10) @(posedge clk);
      conv(8'h06);
      getres();
      chk("abort", r, fx(1, lvl(6)));
      bus(1'b1, 4'hC, 8'h24);
      conv(8'h07);
      getres();
      chk("ref clock", r, fx(1, lvl(7)));
      tally_and_finish();
   end
endmodule : sac_top_tb
bind sac_top sac_assertions #(.PINS(PINS)) i_chk (.clk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
   .selected_analog_input, .conv_power_on, .sample_hold, .conv_irq,
   .port_dir, .shared_port_pins_i, .shared_port_pins_oe, .port_read_data,
   .port_data, .shared_port_pins_o);
